/* radio_core_ctrl_status.v */
// Control and status register bank of the radio link-layer core
//
// Operation
// - Deep-sleep request runs slow-clock power-down sequence
// - Permit drops when sleep-exit interrupt fires
// - Permit active high, read-only status bit
// - Slow-clock rising edge sets edge flag
// - Software writing zero clears edge flag
// - No edge flag while slow timer reset
// - Clock-source bit: 0 slow, 1 master
// - Override bit overrules diagnostic port output
// - Fault mask resets one, gates interrupt
// - Error interrupt level while flag and mask
// - Writing one to clear bit clears flag
// - Clear bit ignores zero, reads zero
// - Unmapped page access sets fault flag
// - Fault flag read-only, cleared only by clear
// - Base register field holds bits 16:10
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "radio_core_consts.vh"

module radio_core_ctrl_status (
    input wire CLK_IN,
    input wire NRST_IN,
    input wire [31:0] ADDR_IN,
    input wire [31:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [31:0] RDATA_OUT,
    input wire SLOW_CLK_IN,
    input wire SLOW_TIMER_RESET_IN,
    input wire MASTER_CLK_ACTIVE_IN,
    input wire SLEEP_EXIT_IRQ_IN,
    input wire XMEM_ACCESS_IN,
    input wire [7:0] XMEM_PAGE_IN,
    input wire [7:0] XMEM_PAGE_MAP_IN,
    input wire [7:0] DIAG_PORT_IN,
    output reg [7:0] DIAG_PORT_OUT,
    output reg RADIO_POWERDOWN_PERMIT_OUT,
    output reg [16:0] XMEM_BASE_ADDR_OUT,
    output reg CORE_ERROR_IRQ_OUT,
    output reg IRQ_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers; first stages feed only second stages
    reg [2:0] slow_sync;
    reg [1:0] trst_sync;
    reg [1:0] src_sync;
    reg [1:0] wake_sync;
    reg wake_prev;

    // Slow clock sampled as data; third stage keeps the edge history
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            slow_sync <= 3'h0;
        end else begin
            slow_sync <= {slow_sync[1:0], SLOW_CLK_IN};
        end
    end

    // Resets to held, so no edge flag before the sync settles
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            trst_sync <= 2'h3;
        end else begin
            trst_sync <= {trst_sync[0], SLOW_TIMER_RESET_IN};
        end
    end

    // Clock-source level, read back only
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            src_sync <= 2'h0;
        end else begin
            src_sync <= {src_sync[0], MASTER_CLK_ACTIVE_IN};
        end
    end

    // Sleep-exit history; idle level low, so no edge after reset
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            wake_sync <= 2'h0;
            wake_prev <= 1'b0;
        end else begin
            wake_sync <= {wake_sync[0], SLEEP_EXIT_IRQ_IN};
            wake_prev <= wake_sync[1];
        end
    end

    wire slow_rise = slow_sync[1] & ~slow_sync[2];
    wire timer_in_reset = trst_sync[1];
    wire wake_rise = wake_sync[1] & ~wake_prev;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    function sel;
        input [31:0] a;
        input [31:0] off;
        begin
            sel = (a == off);
        end
    endfunction

    wire wr_ctrl = WR_IN & sel(ADDR_IN, `OFF_CONTROL);
    wire wr_base = WR_IN & sel(ADDR_IN, `OFF_XMEM_BASE);
    wire wr_mask = WR_IN & sel(ADDR_IN, `OFF_IRQ_MASK);
    wire rd_stat = RD_IN & sel(ADDR_IN, `OFF_IRQ_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // Sleep sequence: counts slow-clock edges after the request
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_DOWN = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [2:0] lp_count;
    reg deep_sleep;
    reg permit;

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (deep_sleep)
                    next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (wake_rise)
                    next_state = ST_IDLE;
                else if (slow_rise && lp_count == `SLEEP_LP_EDGES - 3'h1)
                    next_state = ST_DOWN;
            end
            ST_DOWN: begin
                if (wake_rise)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // request starts the slow-clock sequence
    // A write racing the wake edge wins, so software can re-arm
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            deep_sleep <= 1'b0;
        end else if (wr_ctrl) begin
            deep_sleep <= WDATA_IN[`BIT_DEEP_SLEEP];
        end else if (wake_rise) begin
            deep_sleep <= 1'b0;
        end
    end

    // Counts only in the wait state, so an abort restarts it
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            lp_count <= 3'h0;
        end else if (state != ST_WAIT) begin
            lp_count <= 3'h0;
        end else if (slow_rise) begin
            lp_count <= lp_count + 3'h1;
        end
    end

    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            permit <= 1'b0;
        end else begin
            permit <= (next_state == ST_DOWN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control bits and fault logic
    reg edge_flag;
    reg diag_ovr;
    reg fmask;
    reg fflag;
    reg [`BASE_W-1:0] base_field;
    reg [`IRQ_W-1:0] irq_stat;
    reg [`IRQ_W-1:0] irq_mask;

    wire fault_hit = XMEM_ACCESS_IN & (XMEM_PAGE_IN > XMEM_PAGE_MAP_IN);
    wire permit_rise = (next_state == ST_DOWN) & ~permit;
    wire [`IRQ_W-1:0] events = {wake_rise, permit_rise, fault_hit};

    // set on edge, set wins over clear
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            edge_flag <= 1'b0;
        end else if (slow_rise && !timer_in_reset) begin
            edge_flag <= 1'b1;
        end else if (wr_ctrl && !WDATA_IN[`BIT_EDGE]) begin
            edge_flag <= 1'b0;
        end
    end

    // Plain read-write control bits
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            diag_ovr <= 1'b0;
            fmask <= `FMASK_RST;
        end else if (wr_ctrl) begin
            diag_ovr <= WDATA_IN[`BIT_DIAG_OVR];
            fmask <= WDATA_IN[`BIT_FMASK];
        end
    end

    // hardware set wins, only clear bit clears
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            fflag <= 1'b0;
        end else if (fault_hit) begin
            fflag <= 1'b1;
        end else if (wr_ctrl && WDATA_IN[`BIT_FCLEAR]) begin
            fflag <= 1'b0;
        end
    end

    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            base_field <= `BASE_RST;
        end else if (wr_base) begin
            base_field <= WDATA_IN[`BASE_HI:`BASE_LO];
        end
    end

    // Sticky status, read clears; a simultaneous event is kept
    genvar gi;
    generate
        for (gi = 0; gi < `IRQ_W; gi = gi + 1) begin : g_irq
            always @(posedge CLK_IN or negedge NRST_IN) begin
                if (!NRST_IN) begin
                    irq_stat[gi] <= 1'b0;
                    irq_mask[gi] <= 1'b0;
                end else begin
                    if (events[gi])
                        irq_stat[gi] <= 1'b1;
                    else if (rd_stat)
                        irq_stat[gi] <= 1'b0;
                    if (wr_mask)
                        irq_mask[gi] <= WDATA_IN[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read data and registered outputs
    reg [31:0] rd_word;

    always @* begin
        rd_word = 32'h00000000;
        if (sel(ADDR_IN, `OFF_CONTROL)) begin
            rd_word[`BIT_DEEP_SLEEP] = deep_sleep;
            rd_word[`BIT_PERMIT] = permit;
            rd_word[`BIT_EDGE] = edge_flag;
            // 1 master clock, 0 slow clock
            rd_word[`BIT_CLKSRC] = src_sync[1];
            rd_word[`BIT_DIAG_OVR] = diag_ovr;
            rd_word[`BIT_FMASK] = fmask;
            rd_word[`BIT_FCLEAR] = 1'b0;
            rd_word[`BIT_FFLAG] = fflag;
        end else if (sel(ADDR_IN, `OFF_XMEM_BASE)) begin
            rd_word[`BASE_HI:`BASE_LO] = base_field;
        end else if (sel(ADDR_IN, `OFF_IRQ_STATUS)) begin
            rd_word[`IRQ_W-1:0] = irq_stat;
        end else if (sel(ADDR_IN, `OFF_IRQ_MASK)) begin
            rd_word[`IRQ_W-1:0] = irq_mask;
        end
    end

    // Unmapped reads and idle cycles return zero
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            RDATA_OUT <= 32'h00000000;
        end else begin
            RDATA_OUT <= RD_IN ? rd_word : 32'h00000000;
        end
    end

    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            DIAG_PORT_OUT <= 8'h00;
        end else begin
            DIAG_PORT_OUT <= diag_ovr ? `DIAG_OVR_VAL : DIAG_PORT_IN;
        end
    end

    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            RADIO_POWERDOWN_PERMIT_OUT <= 1'b0;
        end else begin
            RADIO_POWERDOWN_PERMIT_OUT <= (next_state == ST_DOWN);
        end
    end

    // field at bits 16:10, rest zero
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            XMEM_BASE_ADDR_OUT <= 17'h00000;
        end else begin
            XMEM_BASE_ADDR_OUT <= {base_field, 10'h000};
        end
    end

    // level while flag and mask set
    // Fault term ORed in so the pin rises with the flag, not after
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            CORE_ERROR_IRQ_OUT <= 1'b0;
        end else begin
            CORE_ERROR_IRQ_OUT <= (fflag | fault_hit) & fmask;
        end
    end

    // Events ORed in so the pin rises with the sticky bit
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |(irq_stat & irq_mask) | |(events & irq_mask);
        end
    end

endmodule

/* radio_core_consts.vh */
// Register map, field positions and reset values of the radio core control block
`ifndef RADIO_CORE_CONSTS_VH
`define RADIO_CORE_CONSTS_VH

`define ADDR_W 32
`define OFF_CONTROL 32'h40000200
`define OFF_XMEM_BASE 32'h40000208
`define OFF_IRQ_STATUS 32'h40000240
`define OFF_IRQ_MASK 32'h40000244

`define BIT_PERMIT 8
`define BIT_EDGE 7
`define BIT_CLKSRC 6
`define BIT_DIAG_OVR 3
`define BIT_FMASK 2
`define BIT_FCLEAR 1
`define BIT_FFLAG 0
`define BIT_DEEP_SLEEP 31

`define BASE_HI 16
`define BASE_LO 10
`define BASE_W 7
`define BASE_RST 7'h00
`define FMASK_RST 1'b1

`define IRQ_W 3
`define IRQ_FAULT 0
`define IRQ_PERMIT 1
`define IRQ_WAKE 2

`define PAGE_W 8
`define SLEEP_LP_EDGES 3'h3
`define DIAG_W 8
`define DIAG_OVR_VAL 8'h00

`endif

/* radio_core_checker.sv */
// Port-level assertions for the radio core control block
`timescale 1ns/1ps
`include "radio_core_consts.vh"
module radio_core_checker (
    input wire CLK_IN,
    input wire NRST_IN,
    input wire [31:0] ADDR_IN,
    input wire [31:0] WDATA_IN,
    input wire WR_IN,
    input wire SLEEP_EXIT_IRQ_IN,
    input wire XMEM_ACCESS_IN,
    input wire [7:0] XMEM_PAGE_IN,
    input wire [7:0] XMEM_PAGE_MAP_IN,
    input wire [7:0] DIAG_PORT_IN,
    input wire [7:0] DIAG_PORT_OUT,
    input wire RADIO_POWERDOWN_PERMIT_OUT,
    input wire [16:0] XMEM_BASE_ADDR_OUT,
    input wire CORE_ERROR_IRQ_OUT
);
////////////////////////////////////////////////////////////
default clocking @(posedge CLK_IN); endclocking
default disable iff (!NRST_IN);
wire ctl_wr = WR_IN && ADDR_IN == `OFF_CONTROL;
wire base_wr = WR_IN && ADDR_IN == `OFF_XMEM_BASE;
wire bad_acc = XMEM_ACCESS_IN && XMEM_PAGE_IN > XMEM_PAGE_MAP_IN;
sequence mask_off_s; ctl_wr && !WDATA_IN[`BIT_FMASK] ##1 !ctl_wr; endsequence
sequence clear_s; ctl_wr && WDATA_IN[`BIT_FCLEAR] && !bad_acc ##1 !bad_acc; endsequence
sequence base_set_s; base_wr ##1 !base_wr; endsequence
////////////////////////////////////////////////////////////
// Mask write lags one cycle, hence the past term
// level holds
irq_level_hold_a: assert property (CORE_ERROR_IRQ_OUT && !ctl_wr && !$past(ctl_wr)
    |=> CORE_ERROR_IRQ_OUT) else $error("error irq dropped without clear");
irq_needs_fault_a: assert property (!CORE_ERROR_IRQ_OUT && !bad_acc && !ctl_wr
    && !$past(ctl_wr) |=> !CORE_ERROR_IRQ_OUT) else $error("error irq without fault");
mask_gates_irq_a: assert property (mask_off_s |=> !CORE_ERROR_IRQ_OUT)
    else $error("masked fault still raises irq");
clear_drops_a: assert property (clear_s |=> !CORE_ERROR_IRQ_OUT)
    else $error("clear write left irq high");
zero_clear_a: assert property (ctl_wr && !WDATA_IN[`BIT_FCLEAR] && WDATA_IN[`BIT_FMASK]
    && CORE_ERROR_IRQ_OUT && !$past(ctl_wr) |=> CORE_ERROR_IRQ_OUT) else $error("zero cleared");
base_field_a: assert property (base_set_s |=> XMEM_BASE_ADDR_OUT[16:10]
    == $past(WDATA_IN[16:10], 2)) else $error("base field not stored");
base_low_a: assert property (XMEM_BASE_ADDR_OUT[9:0] == 10'h000)
    else $error("base low bits set");
diag_pass_a: assert property (DIAG_PORT_OUT == $past(DIAG_PORT_IN)
    || DIAG_PORT_OUT == `DIAG_OVR_VAL) else $error("diag output corrupted");
permit_drop_a: assert property ($rose(SLEEP_EXIT_IRQ_IN) |-> ##[1:6]
    !RADIO_POWERDOWN_PERMIT_OUT) else $error("permit stayed on wake");
endmodule

/* radio_core_ctrl_status_tb.sv */
// Self-checking testbench of the radio core control block
`timescale 1ns/1ps
`include "radio_core_consts.vh"
module radio_core_ctrl_status_tb;
reg clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, sck = 1'b0, srst = 1'b0;
reg mclk = 1'b0, wake = 1'b0, acc = 1'b0;
reg [31:0] addr = 32'h0, wdata = 32'h0;
reg [7:0] page = 8'h00, pmap = 8'h03, din = 8'h00;
wire [31:0] rdata;
wire [7:0] dout;
wire [16:0] base;
wire permit, eirq, irq;
integer n_fail = 0, num_checks = 0;
always #12.5 clk = ~clk;
radio_core_ctrl_status radio_core_ctrl_status_i (.CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .SLOW_CLK_IN(sck),
    .SLOW_TIMER_RESET_IN(srst), .MASTER_CLK_ACTIVE_IN(mclk), .SLEEP_EXIT_IRQ_IN(wake),
    .XMEM_ACCESS_IN(acc), .XMEM_PAGE_IN(page), .XMEM_PAGE_MAP_IN(pmap), .DIAG_PORT_IN(din),
    .DIAG_PORT_OUT(dout), .RADIO_POWERDOWN_PERMIT_OUT(permit), .XMEM_BASE_ADDR_OUT(base),
    .CORE_ERROR_IRQ_OUT(eirq), .IRQ_OUT(irq));
////////////////////////////////////////////////////////////
task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
task check(input [31:0] g, input [31:0] e);
    num_checks++;
    if (g !== e) begin
        n_fail++;
        $display("ERROR %0t got %h expected %h", $time, g, e);
    end
endtask
task tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
endtask
task wrt(input [31:0] a, input [31:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
endtask
// Read data stand only in the cycle after the strobe
task rdc(input [31:0] a, input [31:0] e, input [31:0] m);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata & m, e);
endtask
// Slow edges spaced wide so the sync always sees them
task slow(input integer n);
    repeat (n) begin
        @(posedge clk) sck <= 1'b1;
        repeat (6) @(posedge clk);
        sck <= 1'b0;
        repeat (6) @(posedge clk);
    end
endtask
task fault(input [7:0] p);
    @(posedge clk) {acc, page} <= {1'b1, p};
    @(posedge clk) acc <= 1'b0;
    #1;
endtask
////////////////////////////////////////////////////////////
task t_reset;
    rdc(`OFF_CONTROL, 32'h4, 32'hFFFFFFFF);
    rdc(`OFF_XMEM_BASE, 32'h0, 32'hFFFFFFFF);
    rdc(32'h40000204, 32'h0, 32'hFFFFFFFF);
    @(posedge clk) mclk <= 1'b1;
    tick(4);
    rdc(`OFF_CONTROL, 32'h40, 32'h40);
    $display("test reset done");
endtask
task t_fault;
    wrt(`OFF_IRQ_MASK, 32'h1);
    fault(8'h03);
    check(32'(eirq), 32'h0);
    fault(8'h05);
    check(32'(eirq), 32'h1);
    check(32'(irq), 32'h1);
    rdc(`OFF_IRQ_STATUS, 32'h1, 32'h1);
    tick(1);
    check(32'(irq), 32'h0);
    wrt(`OFF_CONTROL, 32'h4);
    tick(2);
    check(32'(eirq), 32'h1);
    rdc(`OFF_CONTROL, 32'h1, 32'h3);
    wrt(`OFF_CONTROL, 32'h6);
    tick(2);
    check(32'(eirq), 32'h0);
    wrt(`OFF_CONTROL, 32'h0);
    fault(8'hFF);
    tick(2);
    check(32'(eirq), 32'h0);
    rdc(`OFF_CONTROL, 32'h1, 32'h5);
    wrt(`OFF_CONTROL, 32'h6);
    $display("test fault done");
endtask
task t_edge;
    @(posedge clk) srst <= 1'b1;
    tick(4);
    slow(2);
    rdc(`OFF_CONTROL, 32'h0, 32'h80);
    @(posedge clk) srst <= 1'b0;
    tick(4);
    slow(1);
    rdc(`OFF_CONTROL, 32'h80, 32'h80);
    wrt(`OFF_CONTROL, 32'h84);
    rdc(`OFF_CONTROL, 32'h80, 32'h80);
    wrt(`OFF_CONTROL, 32'h4);
    rdc(`OFF_CONTROL, 32'h0, 32'h80);
    $display("test edge done");
endtask
task t_sleep;
    wrt(`OFF_CONTROL, 32'h80000004);
    slow(3);
    check(32'(permit), 32'h1);
    rdc(`OFF_CONTROL, 32'h80000100, 32'h80000100);
    @(posedge clk) wake <= 1'b1;
    tick(6);
    check(32'(permit), 32'h0);
    @(posedge clk) wake <= 1'b0;
    rdc(`OFF_IRQ_STATUS, 32'h6, 32'h6);
    wrt(`OFF_CONTROL, 32'h80000004);
    slow(1);
    @(posedge clk) wake <= 1'b1;
    tick(6);
    @(posedge clk) wake <= 1'b0;
    slow(3);
    check(32'(permit), 32'h0);
    rdc(`OFF_CONTROL, 32'h0, 32'h80000100);
    $display("test sleep done");
endtask
task t_diag_base;
    @(posedge clk) din <= 8'hA5;
    tick(2);
    check(32'(dout), 32'hA5);
    wrt(`OFF_CONTROL, 32'hC);
    tick(2);
    check(32'(dout), 32'h0);
    wrt(`OFF_XMEM_BASE, 32'hFFFFA400);
    rdc(`OFF_XMEM_BASE, 32'h1A400, 32'hFFFFFFFF);
    check(32'(base), 32'h1A400);
    $display("test diag base done");
endtask
////////////////////////////////////////////////////////////
initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_fault;
    t_edge;
    t_sleep;
    t_diag_base;
    summarize;
end
// Whole run is a few hundred cycles
initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    summarize;
end
endmodule
bind radio_core_ctrl_status radio_core_checker radio_core_checker_i (.CLK_IN, .NRST_IN, .ADDR_IN,
    .WDATA_IN, .WR_IN, .SLEEP_EXIT_IRQ_IN, .XMEM_ACCESS_IN, .XMEM_PAGE_IN, .XMEM_PAGE_MAP_IN,
    .DIAG_PORT_IN, .DIAG_PORT_OUT, .RADIO_POWERDOWN_PERMIT_OUT, .XMEM_BASE_ADDR_OUT,
    .CORE_ERROR_IRQ_OUT);
